// File: logic/mul_pkg.sv
// Shared types and constants of the 8x8 unsigned multiply datapath.
package mul_pkg;

  // ---------------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------------
  localparam logic [7:0] LIT_OPC_HI   = 8'h0D;  // Upper byte of literal form.
  localparam logic [6:0] REG_OPC_HI   = 7'h01;  // Upper seven bits, reg form.
  localparam int         OPC_HI_MSB   = 15;
  localparam int         OPC_LIT_LSB  = 8;
  localparam int         OPC_REG_LSB  = 9;
  localparam int         BANK_BIT     = 8;
  localparam int         OFFSET_MSB   = 7;

  // ---------------------------------------------------------------------
  // Data-memory addressing
  // ---------------------------------------------------------------------
  localparam int         ADDR_W       = 12;
  localparam int         PAGE_W       = ADDR_W - 8;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;  // Low access half ends below.
  localparam logic [7:0] INDEX_LIMIT  = 8'h5F;  // Largest indexed offset.
  localparam logic [PAGE_W-1:0] ACCESS_LO_PAGE = 4'h0;
  localparam logic [PAGE_W-1:0] ACCESS_HI_PAGE = 4'hF;
  localparam logic [15:0] PROD_MAX    = 16'hFE01;  // 255 times 255.

  // ---------------------------------------------------------------------
  // Quarter phases of one instruction cycle
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DECODE,
    PH_READ,
    PH_COMPUTE,
    PH_WRITE
  } phase_t;

  // All state of the multiply unit.
  typedef struct packed {
    phase_t            phase;
    logic [15:0]       opcode;
    logic              is_lit;
    logic [7:0]        wreg;
    logic [7:0]        operand;
    logic              mem_rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       prod;
    logic              prod_we;
    logic              busy;
  } mul_state_t;

  localparam mul_state_t STATE_RESET = '{phase: PH_IDLE, default: '0};

endpackage

// File: logic/mul_unit.sv
// Multiply unit: decodes and executes both 8x8 unsigned multiply forms.
`timescale 1ns/1ps

module mul_unit
  import mul_pkg::*;
(
  input  wire logic              CLK_I,
  input  wire logic              ARST_N_I,
  input  wire logic              INSTR_VALID_I,
  input  wire logic [15:0]       OPCODE_I,
  input  wire logic [7:0]        WREG_I,
  input  wire logic [7:0]        BANK_SEL_I,
  input  wire logic              EXT_SET_I,
  input  wire logic [ADDR_W-1:0] INDEX_BASE_I,
  input  wire logic [7:0]        MEM_DATA_I,
  output logic                   BUSY_O,
  output logic                   MEM_RD_O,
  output logic [ADDR_W-1:0]      MEM_ADDR_O,
  output logic [7:0]             PROD_HI_O,
  output logic [7:0]             PROD_LO_O,
  output logic                   PROD_WE_O
);

  // ---------------------------------------------------------------------
  // State and decode helpers
  // ---------------------------------------------------------------------
  mul_state_t q;
  mul_state_t d;
  logic       accept;
  logic       dec_lit;
  logic       dec_reg;
  logic       bank_bit;
  logic [7:0] offset;
  logic       use_index;

  // A new instruction may start when idle or in the last quarter phase,
  // so back-to-back multiplies run one per instruction cycle.
  assign accept   = INSTR_VALID_I &&
                    (q.phase == PH_IDLE || q.phase == PH_WRITE);
  assign dec_lit  = q.opcode[OPC_HI_MSB:OPC_LIT_LSB] == LIT_OPC_HI;
  assign dec_reg  = q.opcode[OPC_HI_MSB:OPC_REG_LSB] == REG_OPC_HI;
  assign bank_bit = q.opcode[BANK_BIT];
  assign offset   = q.opcode[OFFSET_MSB:0];   // Always unsigned.
  assign use_index = EXT_SET_I && !bank_bit && offset <= INDEX_LIMIT;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  // Status flags are deliberately absent: the unit has no flag port, so no
  // negative, overflow, carry, digit carry or zero indication can leave it.
  always_comb
  begin
    d         = q;
    d.prod_we = 1'b0;
    d.mem_rd  = 1'b0;
    case (q.phase)
      PH_IDLE:
      begin
        if (accept)
        begin
          d.phase  = PH_DECODE;
          d.opcode = OPCODE_I;
          d.wreg   = WREG_I;   // Read only; the accumulator is never driven.
        end
      end
      PH_DECODE:
      begin
        // Decode; anything other than a multiply is not ours to run.
        if (dec_lit)
        begin
          d.phase  = PH_READ;
          d.is_lit = 1'b1;
        end
        else if (dec_reg)
        begin
          d.phase  = PH_READ;
          d.is_lit = 1'b0;
          d.mem_rd = 1'b1;
          if (use_index)
            d.addr = INDEX_BASE_I + {{PAGE_W{1'b0}}, offset};
          else if (bank_bit)
            d.addr = {BANK_SEL_I[PAGE_W-1:0], offset};
          else if (offset < ACCESS_SPLIT)
            d.addr = {ACCESS_LO_PAGE, offset};
          else
            d.addr = {ACCESS_HI_PAGE, offset};
        end
        else
        begin
          d.phase = PH_IDLE;
        end
      end
      PH_READ:
      begin
        // Memory answers in the same quarter; the operand is only read.
        d.phase   = PH_COMPUTE;
        d.operand = q.is_lit ? offset : MEM_DATA_I;
      end
      PH_COMPUTE:
      begin
        // 8x8 unsigned product is at most 16 bits wide, so nothing is lost.
        d.phase   = PH_WRITE;
        d.prod    = 16'(q.wreg) * 16'(q.operand);
        d.prod_we = 1'b1;
      end
      PH_WRITE:
      begin
        if (accept)
        begin
          d.phase  = PH_DECODE;
          d.opcode = OPCODE_I;
          d.wreg   = WREG_I;
        end
        else
        begin
          d.phase = PH_IDLE;
        end
      end
      default:
      begin
        d = STATE_RESET;
      end
    endcase
    // Busy is its own flop, so the port carries no decode logic behind it.
    d.busy = d.phase != PH_IDLE;
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Single register stage keeps every output straight from a flip-flop.
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      q <= STATE_RESET;
    else
      q <= d;
  end

  // Output mapping: high byte and low byte of the product pair.
  assign BUSY_O     = q.busy;
  assign MEM_RD_O   = q.mem_rd;
  assign MEM_ADDR_O = q.addr;
  assign PROD_HI_O  = q.prod[15:8];
  assign PROD_LO_O  = q.prod[7:0];
  assign PROD_WE_O  = q.prod_we;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  logic [15:0] prod_out;
  logic        lit_acc;
  logic        reg_acc;
  assign prod_out = {PROD_HI_O, PROD_LO_O};
  assign lit_acc  = accept &&
                    OPCODE_I[OPC_HI_MSB:OPC_LIT_LSB] == LIT_OPC_HI;
  assign reg_acc  = accept &&
                    OPCODE_I[OPC_HI_MSB:OPC_REG_LSB] == REG_OPC_HI;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  chk_lit_result: assert property (lit_acc |-> ##4 PROD_WE_O &&
    prod_out == 16'($past(WREG_I, 4)) * 16'($past(OPCODE_I[OFFSET_MSB:0], 4)))
    else $error("literal product wrong or late");
  chk_lit_decode: assert property (lit_acc |-> ##2 !MEM_RD_O)
    else $error("literal multiply read memory");
  chk_reg_result: assert property (reg_acc |-> ##2 MEM_RD_O ##2
    PROD_WE_O &&
    prod_out == 16'($past(WREG_I, 4)) * 16'($past(MEM_DATA_I, 2)))
    else $error("register product wrong or late");
  chk_phase_walk: assert property (
    accept |=> q.phase == PH_DECODE
    ##1 (q.phase == PH_IDLE || q.phase == PH_READ))
    else $error("quarter phase sequence broken");
  chk_prod_hold: assert property (
    !PROD_WE_O |-> $stable(prod_out))
    else $error("product pair changed outside write phase");
  chk_prod_fits: assert property (
    PROD_WE_O |-> prod_out <= PROD_MAX)
    else $error("product exceeds 8x8 range");
  chk_access_bank: assert property (
    q.phase == PH_DECODE && dec_reg && !bank_bit && !EXT_SET_I
    |=> MEM_ADDR_O[OFFSET_MSB:0] == $past(offset) &&
    MEM_ADDR_O[ADDR_W-1:OFFSET_MSB+1] == ($past(offset) < ACCESS_SPLIT ?
    ACCESS_LO_PAGE : ACCESS_HI_PAGE))
    else $error("access bank address wrong");
  chk_bank_select: assert property (
    q.phase == PH_DECODE && dec_reg && bank_bit
    |=> MEM_ADDR_O == {$past(BANK_SEL_I[PAGE_W-1:0]), $past(offset)})
    else $error("banked address wrong");
  chk_indexed: assert property (
    q.phase == PH_DECODE && dec_reg && use_index
    |=> MEM_ADDR_O == $past(INDEX_BASE_I) + ADDR_W'($past(offset)))
    else $error("indexed address wrong");
  chk_zero_kept: assert property (
    lit_acc && OPCODE_I[OFFSET_MSB:0] == 8'h00
    |-> ##4 PROD_WE_O && prod_out == 16'h0000)
    else $error("zero product not written");
  chk_other_quiet: assert property (
    q.phase == PH_DECODE && !dec_lit && !dec_reg
    |=> !MEM_RD_O ##1 !PROD_WE_O)
    else $error("non-multiply opcode acted");

  cov_lit: cover property (lit_acc ##4 PROD_WE_O);
  cov_reg_banked: cover property (reg_acc ##1 bank_bit ##3 PROD_WE_O);
  cov_indexed: cover property (q.phase == PH_DECODE && dec_reg && use_index);
  cov_back_to_back: cover property (PROD_WE_O && accept);

endmodule

// File: verif/tb_mul_unit.sv
// Self-checking testbench of the 8x8 unsigned multiply unit.
`timescale 1ns/1ps

module tb_mul_unit;
  import mul_pkg::*;

  // ------------------------------------------------------------------
  // Stimulus table and signals
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] op;
    logic [7:0]  w;
    logic [7:0]  bank_select_register;
    logic        ext;
    logic [11:0] base;
    logic [11:0] addr;
    logic        rd;
  } row_t;

  // Literal rows first, then every bank and index mode of the file form.
  localparam row_t ROWS [10] = '{
    '{16'h0DC4, 8'hE2, 8'h00, 1'b0, 12'h000, 12'h000, 1'b0},
    '{16'h0D00, 8'hFF, 8'h00, 1'b0, 12'h000, 12'h000, 1'b0},
    '{16'h0DFF, 8'hFF, 8'h00, 1'b0, 12'h000, 12'h000, 1'b0},
    '{16'h0310, 8'hC4, 8'h02, 1'b0, 12'h000, 12'h210, 1'b1},
    '{16'h03FF, 8'h11, 8'hF7, 1'b0, 12'h000, 12'h7FF, 1'b1},
    '{16'h025F, 8'h33, 8'h0A, 1'b0, 12'h000, 12'h05F, 1'b1},
    '{16'h0260, 8'h44, 8'h0A, 1'b0, 12'h000, 12'hF60, 1'b1},
    '{16'h025F, 8'h55, 8'h00, 1'b1, 12'hFC0, 12'h01F, 1'b1},
    '{16'h0260, 8'h66, 8'h00, 1'b1, 12'h100, 12'hF60, 1'b1},
    '{16'h0310, 8'h77, 8'h03, 1'b1, 12'h800, 12'h310, 1'b1}};

  logic        clk        = 1'b0;
  logic        arst_n     = 1'b0;
  logic        valid      = 1'b0;
  logic [15:0] opcode     = 16'h0000;
  logic [7:0]  wreg       = 8'h00;
  logic [7:0]  bank_sel   = 8'h00;
  logic        ext_set    = 1'b0;
  logic [11:0] index_base = 12'h000;
  logic [7:0]  mem_data;
  logic        busy;
  logic        mem_rd;
  logic [11:0] mem_addr;
  logic [7:0]  prod_hi;
  logic [7:0]  prod_lo;
  logic        prod_we;
  int          n_fail      = 0;
  int          comparisons = 0;

  // A 20 MHz clock.
  always #25 clk = ~clk;

  // Memory contents differ per page, so a wrong bank gives a wrong product.
  function automatic logic [7:0] mem_fn(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  // Combinational read answer, as the unit expects.
  always_comb mem_data = mem_fn(mem_addr);

  mul_unit i_dut (
    .CLK_I         (clk),
    .ARST_N_I      (arst_n),
    .INSTR_VALID_I (valid),
    .OPCODE_I      (opcode),
    .WREG_I        (wreg),
    .BANK_SEL_I    (bank_sel),
    .EXT_SET_I     (ext_set),
    .INDEX_BASE_I  (index_base),
    .MEM_DATA_I    (mem_data),
    .BUSY_O        (busy),
    .MEM_RD_O      (mem_rd),
    .MEM_ADDR_O    (mem_addr),
    .PROD_HI_O     (prod_hi),
    .PROD_LO_O     (prod_lo),
    .PROD_WE_O     (prod_we)
  );

  // ------------------------------------------------------------------
  // Compare, issue and closing tasks
  // ------------------------------------------------------------------
  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Drives one instruction; operands stay up so decode sees them too.
  task automatic issue(input row_t r);
    @(posedge clk);
    valid      <= 1'b1;
    opcode     <= r.op;
    wreg       <= r.w;
    bank_sel   <= r.bank_select_register;
    ext_set    <= r.ext;
    index_base <= r.base;
  endtask

  // One whole instruction, checked phase by phase.
  task automatic run(input row_t r);
    logic [7:0] b;
    b = r.rd ? mem_fn(r.addr) : r.op[7:0];
    issue(r);
    @(posedge clk);
    valid <= 1'b0;
    #1;
    chk_flag(busy, 1'b1);
    // The read strobe stands only in the second quarter phase.
    @(posedge clk);
    #1;
    chk_flag(mem_rd, r.rd);
    chk_flag(prod_we, 1'b0);
    if (r.rd)
      chk_val({4'h0, mem_addr}, {4'h0, r.addr});
    repeat (2) @(posedge clk);
    #1;
    chk_flag(prod_we, 1'b1);
    chk_flag(mem_rd, 1'b0);
    chk_val({prod_hi, prod_lo}, {8'h00, r.w} * {8'h00, b});
    @(posedge clk);
    #1;
    chk_flag(busy, 1'b0);
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    // Reset starts low with no falling edge, so the first clock applies it.
    @(posedge clk);
    #1;
    chk_val({busy, prod_we, mem_rd, 1'b0, mem_addr}, 16'h0000);
    chk_val({prod_hi, prod_lo}, 16'h0000);
    repeat (7) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ROWS[i]) run(ROWS[i]);
    // Held request: refused while busy, taken in the write cycle.
    issue('{16'h0D03, 8'h07, 8'h00, 1'b0, 12'h000, 12'h000, 1'b0});
    @(posedge clk);
    opcode <= 16'h0D05;
    wreg   <= 8'h09;
    repeat (3) @(posedge clk);
    #1;
    chk_val({prod_hi, prod_lo}, 16'h0015);
    @(posedge clk);
    valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_flag(prod_we, 1'b1);
    chk_val({prod_hi, prod_lo}, 16'h002D);
    // A neighbouring opcode must neither read nor write.
    issue('{16'h0E55, 8'h0B, 8'h00, 1'b0, 12'h000, 12'h000, 1'b0});
    repeat (5)
    begin
      @(posedge clk);
      valid <= 1'b0;
      #1;
      chk_flag(prod_we | mem_rd, 1'b0);
    end
    chk_val({prod_hi, prod_lo}, 16'h002D);
    // Reset in mid-instruction clears everything at once.
    run(ROWS[2]);
    issue(ROWS[0]);
    repeat (2) @(posedge clk);
    arst_n <= 1'b0;
    valid  <= 1'b0;
    #1;
    chk_val({busy, prod_we, mem_rd, 1'b0, mem_addr}, 16'h0000);
    chk_val({prod_hi, prod_lo}, 16'h0000);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    run(ROWS[3]);
    end_sim();
  end

  // The run needs about 100 cycles; this allows far more.
  initial
  begin
    #50000;
    n_fail++;
    end_sim();
  end

endmodule
